/* rtl/csfi_top.sv */
`timescale 1ns/1ps
module csfi_top
  import csfi_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = CSFI_BUF_DEPTH
)(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic sclk_in,
  input wire logic fsync_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic irq_out
);
  if (BUF_DEPTH < 1 || BUF_DEPTH > CSFI_BUF_DEPTH)
  begin : g_bad_depth
    $error("BUF_DEPTH must be 1 to 4");
  end
  localparam logic [1:0] LAST_MAX = 2'(BUF_DEPTH - 1);

  // ****************************************
  // Registers
  // ****************************************
  csfi_ctrl_t ctrl;
  logic [15:0] tx_slot_en;
  logic [15:0] rx_slot_en;
  logic [CSFI_EV_W-1:0] status;
  logic [CSFI_EV_W-1:0] irq_en;
  logic [15:0] tx_buf [CSFI_BUF_DEPTH];
  logic [15:0] rx_buf [CSFI_BUF_DEPTH];

  // ****************************************
  // Link sampling
  // ****************************************
  csfi_link_t link_s1;
  csfi_link_t link_s2;
  csfi_link_t link_s3;
  logic fs_prev;
  logic active;
  logic [3:0] slot;
  logic [3:0] bit_cnt;
  logic [1:0] tx_ptr;
  logic [1:0] rx_ptr;
  logic [15:0] rx_shift;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic word_end;
  logic [1:0] last_ptr;
  logic [15:0] word_mask;
  logic tx_wrap;
  logic rx_wrap;
  logic [CSFI_EV_W-1:0] ev_set;
  logic [CSFI_EV_W-1:0] ev_clr;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      link_s1 <= '0;
      link_s2 <= '0;
      link_s3 <= '0;
    end
    else
    begin
      link_s1 <= '{sclk: sclk_in, fsync: fsync_in, sdi: sdi_in};
      link_s2 <= link_s1;
      link_s3 <= link_s2;
    end
  end

  assign sclk_rise = link_s2.sclk & ~link_s3.sclk;
  assign sclk_fall = ~link_s2.sclk & link_s3.sclk;
  assign frame_start = sclk_rise & ctrl.enable &
    ((ctrl.mode == CSFI_MODE_I2S) ? (fs_prev & ~link_s2.fsync)
                                  : (~fs_prev & link_s2.fsync));
  assign word_end = sclk_rise & active & (bit_cnt == ctrl.wlen_m1);
  assign last_ptr = (ctrl.batch_m1 > LAST_MAX) ? LAST_MAX : ctrl.batch_m1;
  assign word_mask = 16'hFFFF >> (4'hF - ctrl.wlen_m1);
  assign tx_wrap = word_end & tx_slot_en[slot] & (tx_ptr == last_ptr);
  assign rx_wrap = word_end & rx_slot_en[slot] & (rx_ptr == last_ptr);
  assign ev_set = {rx_wrap & status[CSFI_EV_RX], rx_wrap, tx_wrap};

  // ****************************************
  // Frame and slot timing
  // ****************************************
  // Restart on the mode's sync edge (falling for I2S, rising otherwise), so frames shorter than 16 slots also work
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      fs_prev <= 1'b0;
      active <= 1'b0;
      slot <= 4'h0;
      bit_cnt <= 4'h0;
    end
    else if (sclk_rise)
    begin
      fs_prev <= link_s2.fsync;
      if (!ctrl.enable)
        active <= 1'b0;
      else if (frame_start)
      begin
        active <= 1'b1;
        slot <= 4'h0;
        bit_cnt <= 4'h0;
      end
      else if (word_end)
      begin
        bit_cnt <= 4'h0;
        slot <= slot + 4'h1;
        if (slot == CSFI_LAST_SLOT)
          active <= 1'b0;
      end
      else if (active)
        bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rx_shift <= 16'h0000;
      rx_ptr <= 2'h0;
      for (int i = 0; i < CSFI_BUF_DEPTH; i++)
        rx_buf[i] <= 16'h0000;
    end
    else if (sclk_rise && active && rx_slot_en[slot])
    begin
      rx_shift <= {rx_shift[14:0], link_s2.sdi};
      if (word_end)
      begin
        rx_buf[rx_ptr] <= {rx_shift[14:0], link_s2.sdi} & word_mask;
        rx_ptr <= (rx_ptr == last_ptr) ? 2'h0 : rx_ptr + 2'h1;
      end
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  // Data launch on the sampled falling edge, about three system clocks late;
  // fine for the 320 ns bit clock, tight for much faster links
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end
    else if (sclk_fall)
    begin
      if (active && tx_slot_en[slot])
      begin
        sdo_out <= tx_buf[tx_ptr][ctrl.wlen_m1 - bit_cnt];
        sdo_oe_out <= 1'b1;
      end
      else
      begin
        sdo_out <= 1'b0;
        sdo_oe_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      tx_ptr <= 2'h0;
    else if (word_end && tx_slot_en[slot])
      tx_ptr <= (tx_ptr == last_ptr) ? 2'h0 : tx_ptr + 2'h1;
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [31:0] w_mask;
  logic do_write;
  logic wr_ok;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [31:0] wr_val;

  assign s_axi_awready_out = ~aw_hold;
  assign s_axi_wready_out = ~w_hold;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid_out;
  assign wr_val = w_data & w_mask;
  assign ev_clr = (do_write && aw_addr == CSFI_OFF_CLEAR) ?
                  wr_val[CSFI_EV_W-1:0] : '0;
  assign irq_out = |(status & irq_en);

  always_comb
  begin
    wr_ok = 1'b1;
    case (aw_addr)
      CSFI_OFF_CTRL, CSFI_OFF_TX_SLOT, CSFI_OFF_RX_SLOT, CSFI_OFF_STATUS,
      CSFI_OFF_CLEAR, CSFI_OFF_IRQ_EN, CSFI_OFF_STATE: wr_ok = 1'b1;
      default: wr_ok = (aw_addr[7:4] == CSFI_PAGE_TX_BUF ||
                        aw_addr[7:4] == CSFI_PAGE_RX_BUF) &&
                       ({2'h0, aw_addr[3:2]} < 4'(BUF_DEPTH));
    endcase
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr_in)
      CSFI_OFF_CTRL: rd_data = 32'(ctrl);
      CSFI_OFF_TX_SLOT: rd_data = {16'h0000, tx_slot_en};
      CSFI_OFF_RX_SLOT: rd_data = {16'h0000, rx_slot_en};
      CSFI_OFF_STATUS: rd_data = 32'(status);
      CSFI_OFF_CLEAR: rd_data = 32'h0000_0000;
      CSFI_OFF_IRQ_EN: rd_data = 32'(irq_en);
      CSFI_OFF_STATE: rd_data = 32'({active, slot, tx_ptr, rx_ptr});
      default:
      begin
        rd_ok = {2'h0, s_axi_araddr_in[3:2]} < 4'(BUF_DEPTH);
        if (s_axi_araddr_in[7:4] == CSFI_PAGE_TX_BUF && rd_ok)
          rd_data = {16'h0000, tx_buf[s_axi_araddr_in[3:2]]};
        else if (s_axi_araddr_in[7:4] == CSFI_PAGE_RX_BUF && rd_ok)
          rd_data = {16'h0000, rx_buf[s_axi_araddr_in[3:2]]};
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_mask <= 32'h0000_0000;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= CSFI_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_hold)
      begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr_in[7:2], 2'h0};
      end
      if (s_axi_wvalid_in && !w_hold)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_in;
        for (int b = 0; b < 4; b++)
          w_mask[b*8 +: 8] <= {8{s_axi_wstrb_in[b]}};
      end
      if (do_write)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_ok ? CSFI_RESP_OKAY : CSFI_RESP_SLVERR;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= CSFI_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && !s_axi_rvalid_out)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_data;
      s_axi_rresp_out <= rd_ok ? CSFI_RESP_OKAY : CSFI_RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

  // Byte lanes merge into the old value so partial writes keep the rest
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      ctrl <= CSFI_CTRL_RST;
      tx_slot_en <= CSFI_SLOT_RST;
      rx_slot_en <= CSFI_SLOT_RST;
      irq_en <= '0;
      for (int i = 0; i < CSFI_BUF_DEPTH; i++)
        tx_buf[i] <= 16'h0000;
    end
    else if (do_write)
    begin
      case (aw_addr)
        CSFI_OFF_CTRL:
          ctrl <= (ctrl & ~w_mask[8:0]) | wr_val[8:0];
        CSFI_OFF_TX_SLOT:
          tx_slot_en <= (tx_slot_en & ~w_mask[15:0]) | wr_val[15:0];
        CSFI_OFF_RX_SLOT:
          rx_slot_en <= (rx_slot_en & ~w_mask[15:0]) | wr_val[15:0];
        CSFI_OFF_IRQ_EN:
          irq_en <= (irq_en & ~w_mask[2:0]) | wr_val[2:0];
        default:
          if (aw_addr[7:4] == CSFI_PAGE_TX_BUF && wr_ok)
            tx_buf[aw_addr[3:2]] <= (tx_buf[aw_addr[3:2]] & ~w_mask[15:0]) |
                                    wr_val[15:0];
      endcase
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      status <= '0;
    else
      status <= (status & ~ev_clr) | ev_set;
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Sync level after the start edge is low for I2S, high otherwise
  property p_mode_edge;
    @(posedge sys_clk_in) disable iff (srst_in)
    frame_start |=> active && slot == 4'h0 && bit_cnt == 4'h0 &&
      (fs_prev == (ctrl.mode != CSFI_MODE_I2S));
  endproperty
  a_mode_edge: assert property (p_mode_edge)
    else $error("frame start did not open slot zero");
  property p_tx_event;
    @(posedge sys_clk_in) disable iff (srst_in)
    $rose(status[CSFI_EV_TX]) |-> $past(tx_ptr) == $past(last_ptr);
  endproperty
  a_tx_event: assert property (p_tx_event)
    else $error("transmit batch flag without a full batch");
  property p_ptr_bound;
    @(posedge sys_clk_in) disable iff (srst_in)
    rx_ptr <= last_ptr || $changed(last_ptr);
  endproperty
  a_ptr_bound: assert property (p_ptr_bound)
    else $error("receive pointer beyond batch size");
  property p_bit_bound;
    @(posedge sys_clk_in) disable iff (srst_in)
    active && !$changed(ctrl.wlen_m1) |-> bit_cnt <= ctrl.wlen_m1;
  endproperty
  a_bit_bound: assert property (p_bit_bound)
    else $error("bit counter past word length");
  property p_rx_step;
    @(posedge sys_clk_in) disable iff (srst_in)
    word_end && rx_slot_en[slot] && rx_ptr != last_ptr |=>
      rx_ptr == $past(rx_ptr) + 2'h1;
  endproperty
  a_rx_step: assert property (p_rx_step)
    else $error("receive pointer did not step");
  property p_frame_end;
    @(posedge sys_clk_in) disable iff (srst_in)
    word_end && slot == CSFI_LAST_SLOT && !frame_start |=> !active;
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("frame ran past sixteen slots");
  property p_tx_slot;
    @(posedge sys_clk_in) disable iff (srst_in)
    $rose(sdo_oe_out) |-> $past(active) && $past(tx_slot_en[slot]);
  endproperty
  a_tx_slot: assert property (p_tx_slot)
    else $error("driving in a slot without transmit enable");
  property p_release;
    @(posedge sys_clk_in) disable iff (srst_in)
    sclk_fall && !active |=> !sdo_oe_out [*2];
  endproperty
  a_release: assert property (p_release)
    else $error("output driven outside a frame");
  c_tx_batch: cover property (@(posedge sys_clk_in) $rose(status[0]));
  c_rx_batch: cover property (@(posedge sys_clk_in) $rose(status[1]));
  c_i2s_start: cover property (@(posedge sys_clk_in)
    frame_start && ctrl.mode == CSFI_MODE_I2S);
endmodule

/* rtl/csfi_pkg.sv */
package csfi_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int unsigned CSFI_ADDR_W = 8;
  localparam logic [7:0] CSFI_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSFI_OFF_TX_SLOT = 8'h04;
  localparam logic [7:0] CSFI_OFF_RX_SLOT = 8'h08;
  localparam logic [7:0] CSFI_OFF_STATUS = 8'h0C;
  localparam logic [7:0] CSFI_OFF_CLEAR = 8'h10;
  localparam logic [7:0] CSFI_OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] CSFI_OFF_STATE = 8'h18;
  localparam logic [3:0] CSFI_PAGE_TX_BUF = 4'h2;
  localparam logic [3:0] CSFI_PAGE_RX_BUF = 4'h3;
  // ****************************************
  // Modes, sizes, events
  // ****************************************
  localparam logic [1:0] CSFI_MODE_FRAMED = 2'h0;
  localparam logic [1:0] CSFI_MODE_I2S = 2'h1;
  localparam logic [1:0] CSFI_MODE_ACLINK = 2'h2;
  localparam int unsigned CSFI_SLOTS = 16;
  localparam int unsigned CSFI_MAX_WORD = 16;
  localparam int unsigned CSFI_BUF_DEPTH = 4;
  localparam logic [3:0] CSFI_LAST_SLOT = 4'hF;
  localparam int unsigned CSFI_EV_W = 3;
  localparam int unsigned CSFI_EV_TX = 0;
  localparam int unsigned CSFI_EV_RX = 1;
  localparam int unsigned CSFI_EV_OVR = 2;
  localparam logic [15:0] CSFI_SLOT_RST = 16'h0000;
  localparam logic [1:0] CSFI_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSFI_RESP_SLVERR = 2'h2;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] batch_m1;
    logic [3:0] wlen_m1;
    logic [1:0] mode;
    logic enable;
  } csfi_ctrl_t;
  localparam csfi_ctrl_t CSFI_CTRL_RST = 9'h000;
  typedef struct packed {
    logic sclk;
    logic fsync;
    logic sdi;
  } csfi_link_t;
endpackage

/* tb/csfi_codec_model.sv */
`timescale 1ns/1ps
// ****************************************
// Codec side of the link, clock stands still between frames
// ****************************************
module csfi_codec_model
  import csfi_pkg::*;
(
  output logic sclk_out,
  output logic fsync_out,
  output logic sdi_out,
  output logic busy_out
);
  initial
  begin
    sclk_out = 1'b0;
    fsync_out = 1'b0;
    sdi_out = 1'b0;
    busy_out = 1'b0;
  end
  // Released data line toggles so a stale bit never matches
  always #40
    if (!busy_out)
      sdi_out = ~sdi_out;
  task automatic run(input int n, input logic [271:0] rx,
                     input logic [1:0] m);
    logic idle;
    idle = (m == CSFI_MODE_I2S);
    #13 fsync_out = idle;
    #160 sclk_out = 1'b1;
    #160 sclk_out = 1'b0;
    fsync_out = ~idle;
    #160 sclk_out = 1'b1;
    #160 sclk_out = 1'b0;
    fsync_out = idle;
    busy_out = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      sdi_out = rx[i];
      #160 sclk_out = 1'b1;
      #160 sclk_out = 1'b0;
    end
    busy_out = 1'b0;
  endtask
endmodule

/* tb/csfi_top_test.sv */
`timescale 1ns/1ps
module csfi_top_test
  import csfi_pkg::*;
;
  localparam logic [7:0] RST_REGS [6] = '{CSFI_OFF_CTRL, CSFI_OFF_TX_SLOT,
    CSFI_OFF_RX_SLOT, CSFI_OFF_STATUS, CSFI_OFF_IRQ_EN, CSFI_OFF_STATE};
  logic clk, rst, awvalid, wvalid, arvalid, bready, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, sdo, oe;
  logic sclk, fsync, sdi, busy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [1:0] sq[$];
  int err_total, comparisons, cyc;
  csfi_top dut (
    .sys_clk_in(clk),
    .srst_in(rst),
    .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready),
    .sclk_in(sclk),
    .fsync_in(fsync),
    .sdi_in(sdi),
    .sdo_out(sdo),
    .sdo_oe_out(oe),
    .irq_out(irq)
  );
  csfi_codec_model cod (.sclk_out(sclk), .fsync_out(fsync),
    .sdi_out(sdi), .busy_out(busy));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string nm, input logic [33:0] seen,
                       input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Ceiling covers four frames of 16 long slots with margin
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      end_sim();
    end
  end
  always @(posedge clk)
  begin
    if (rvalid && rready)
      check("rdata", {rresp, rdata}, rq.pop_front());
    if (bvalid && bready)
      check("bresp", 34'(bresp), 34'(bq.pop_front()));
  end
  always @(posedge sclk)
    if (busy)
      check("sdo", 34'({oe, oe & sdo}), 34'(sq.pop_front()));
  // ****************************************
  // Bus master
  // ****************************************
  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bit aw, w;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 0;
    w = 0;
    do
    begin
      @(posedge clk);
      aw = aw | awready;
      w = w | wready;
      awvalid <= !aw;
      wvalid <= !w;
    end while (!(aw && w));
    do @(posedge clk); while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    logic [31:0] tx[4];
    logic [15:0] txm, rxm, acc, rw[4];
    logic [271:0] rxb;
    logic [2:0] en, st;
    csfi_ctrl_t c;
    int wl, bt, tp, rp, nt, nr, s, b;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    void'($urandom(32'hC805094F));
    do_reset();
    foreach (RST_REGS[i])
      rd(RST_REGS[i], 34'h0);
    rd(8'h1C, {CSFI_RESP_SLVERR, 32'h0});
    wr(8'h1C, 32'h1, CSFI_RESP_SLVERR);
    wr(CSFI_OFF_STATUS, 32'h7, CSFI_RESP_OKAY);
    rd(CSFI_OFF_STATUS, 34'h0);
    for (int k = 0; k < 4; k++)
    begin
      do_reset();
      wl = (k == 0) ? 16 : $urandom_range(16, 1);
      bt = $urandom_range(4, 1);
      c = '{batch_m1: 2'(bt - 1), wlen_m1: 4'(wl - 1), mode: 2'(k % 3),
            enable: 1'b1};
      txm = (k == 0) ? 16'hFFFF : 16'($urandom);
      rxm = 16'($urandom);
      en = 3'($urandom);
      wr(CSFI_OFF_CTRL, 32'(c), CSFI_RESP_OKAY);
      rd(CSFI_OFF_CTRL, 34'(c));
      wr(CSFI_OFF_TX_SLOT, 32'(txm), CSFI_RESP_OKAY);
      wr(CSFI_OFF_RX_SLOT, 32'(rxm), CSFI_RESP_OKAY);
      wr(CSFI_OFF_IRQ_EN, 32'(en), CSFI_RESP_OKAY);
      for (int n = 0; n < 4; n++)
      begin
        tx[n] = $urandom_range(32'hFFFF, 0);
        rw[n] = 16'h0;
        wr({CSFI_PAGE_TX_BUF, 2'(n), 2'b00}, tx[n], CSFI_RESP_OKAY);
      end
      tp = 0;
      rp = 0;
      nt = 0;
      nr = 0;
      // Four bits past slot 15 must stay undriven
      for (int i = 0; i < 16 * wl + 4; i++)
      begin
        s = i / wl;
        b = i % wl;
        rxb[i] = 1'($urandom);
        acc = (b == 0) ? 16'(rxb[i]) : {acc[14:0], rxb[i]};
        sq.push_back((s < 16 && txm[s]) ? {1'b1, tx[tp][wl - 1 - b]} : 2'h0);
        if (b == wl - 1 && s < 16)
        begin
          if (rxm[s])
            rw[rp] = acc;
          rp = (rp + rxm[s]) % bt;
          nr += rxm[s];
          tp = (tp + txm[s]) % bt;
          nt += txm[s];
        end
      end
      cod.run(16 * wl + 4, rxb, c.mode);
      repeat (4) @(posedge clk);
      for (int n = 0; n < 4; n++)
        rd({CSFI_PAGE_RX_BUF, 2'(n), 2'b00}, 34'(rw[n]));
      st = {nr >= 2 * bt, nr >= bt, nt >= bt};
      rd(CSFI_OFF_STATUS, 34'(st));
      check("irq", 34'(irq), 34'(|(st & en)));
      wr(CSFI_OFF_CLEAR, 32'h7, CSFI_RESP_OKAY);
      rd(CSFI_OFF_STATUS, 34'h0);
      check("irq", 34'(irq), 34'h0);
    end
    end_sim();
  end
endmodule
